// >>> rtl/rxf_defines.vh
// Constants for the receive framer, parity and clock-select block.
`ifndef RXF_DEFINES_VH
`define RXF_DEFINES_VH
// Three-level select encodings.
`define RXF_LVL_LOW 2'h0
`define RXF_LVL_MID 2'h1
`define RXF_LVL_HIGH 2'h2
// Framing patterns, 10-bit code groups (bit 0 received first).
`define RXF_K285_NEG 10'h0_17c
`define RXF_K285_POS 10'h0_283
`define RXF_COMMA_NEG 7'h7c
`define RXF_COMMA_POS 7'h03
// Alternate framer needs this many aligned framing characters in a row.
`define RXF_ALIGN_COUNT 3'h4
// Character width and FIFO shape.
`define RXF_CHAR_W 10
`define RXF_FIFO_DEPTH 16
// APB register byte addresses.
`define RXF_ADDR_CTRL 12'h0_000
`define RXF_ADDR_STATUS 12'h0_004
`define RXF_ADDR_TXWORD 12'h0_008
`define RXF_ADDR_RXWORD 12'h0_00c
// Control register field positions.
`define RXF_CTRL_FRMODE 1:0
`define RXF_CTRL_FRCHAR 3:2
`define RXF_CTRL_PARITY 5:4
`define RXF_CTRL_TXMODE1 6
`define RXF_CTRL_DECODER_SELECT 8:7
`define RXF_CTRL_TX_CLOCK_SOURCE_SELECT 9
`define RXF_CTRL_RX_CLOCK_SOURCE_SELECT 10
`define RXF_CTRL_REFRAME 11
`define RXF_CTRL_RESET 32'h0000_0000
`endif

// >>> rtl/rxf_fifo.v
// Parameterised valid/ready FIFO used as the receive elasticity buffer.
`timescale 1ns/1ps
module rxf_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  // Full and empty follow the occupancy count exactly.
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  assign level = count;

  // Storage has no reset; only the pointers define content.
  always @(posedge pclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointer and count update.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// >>> rtl/rxf_top.v
// Receive framer, parity check/generate and elasticity buffer with an APB slave.
//
// Summary of operation
// R01: Alternate framer realigns only after four aligned framing characters in a row.
// R02: Realignment never moves the character clock; one clock stays in phase.
// R03: Framing select at middle level searches both disparities of the comma.
// R04: Framing select high searches both disparities of the full K28.5.
// R05: Host must not set framing select low; that level is test only.
// R06: Parity control low disables checking and releases receive parity output.
// R07: Parity middle, coding on: odd parity over data byte and parity bit.
// R08: Parity middle, coding bypassed: parity also covers control and status 1:0.
// R09: Parity high: check covers data, control; generate covers status 2:0.
// R10: Transmit clock select low: transmit words timed by the reference clock.
// R11: Receive clock select low: elasticity buffer used, output on reference clock.
// R12: Buffer compensates offset only by adding or dropping framing characters.
// R13: Adding inserts one K28.5 right after a buffered framing character.
// R14: Dropping removes a framing character where it is seen in the buffer.
// R15: Framer realigns only while reframe allow is high.
// R16: Decoder select low passes raw 10-bit characters to the receive output.
// R17: Host changes static settings only while the block is held in reset; ctrl here clears in reset and takes writes only after release.
// R18: Transmit parity mismatch is flagged as a sticky error to the host.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "rxf_defines.vh"
module rxf_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4,
  parameter LOW_MARK = 4,
  parameter HIGH_MARK = 12
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rx_serial_in,
  output wire rx_word_ready,
  output reg [7:0] rx_data_out,
  output reg [2:0] rx_status_out,
  output reg rx_parity_out,
  output reg rx_parity_oe,
  output reg tx_parity_error
);
  localparam CW = `RXF_CHAR_W;

  // ----------------------------------------------------------------
  // Control register and APB slave
  // ----------------------------------------------------------------
  reg [31:0] ctrl;
  reg tx_perr_sticky;
  reg [2*CW-1:0] shreg;
  reg [CW-1:0] rx_char;
  reg [3:0] bit_cnt;
  reg [3:0] phase;
  reg [2:0] align_run;
  reg [3:0] cand_phase;
  reg locked;
  reg char_strobe;
  reg [CW-1:0] held_char;
  reg held_valid;
  reg insert_pend;
  reg [9:0] rx_word;
  reg rx_word_valid;
  reg sync0;
  wire [1:0] frmode = ctrl[`RXF_CTRL_FRMODE];
  wire [1:0] frchar = ctrl[`RXF_CTRL_FRCHAR];
  wire [1:0] parity_control_select = ctrl[`RXF_CTRL_PARITY];
  wire tx_mode_bit1 = ctrl[`RXF_CTRL_TXMODE1];
  wire [1:0] decoder_select = ctrl[`RXF_CTRL_DECODER_SELECT];
  wire rx_clock_source_select = ctrl[`RXF_CTRL_RX_CLOCK_SOURCE_SELECT];
  wire reframe_allow = ctrl[`RXF_CTRL_REFRAME];
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr_ctrl = access && pwrite && (paddr == `RXF_ADDR_CTRL);
  // R10: transmit words taken on reference clock
  wire wr_tx = access && pwrite && (paddr == `RXF_ADDR_TXWORD);
  // The word is consumed at the setup edge, where prdata captures it, so a word landing later survives.
  wire rd_rx = setup && !pwrite && (paddr == `RXF_ADDR_RXWORD);
  wire mapped = (paddr == `RXF_ADDR_CTRL) || (paddr == `RXF_ADDR_STATUS) ||
                (paddr == `RXF_ADDR_TXWORD) || (paddr == `RXF_ADDR_RXWORD);

  // Zero wait states; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Odd parity is true when the covered bits plus parity hold an odd count of ones.
  function odd_ok;
    input [10:0] bits;
    begin
      odd_ok = ^bits;
    end
  endfunction

  // Framing-character match on a 10-bit window.
  function frame_hit;
    input [CW-1:0] c;
    input [1:0] sel;
    begin
      // R03: comma search
      if (sel == `RXF_LVL_MID) begin
        frame_hit = (c[6:0] == `RXF_COMMA_NEG) || (c[6:0] == `RXF_COMMA_POS);
      // R04: full K28.5 search
      end else if (sel == `RXF_LVL_HIGH) begin
        frame_hit = (c == `RXF_K285_NEG) || (c == `RXF_K285_POS);
      end else begin
        frame_hit = 1'b0;
      end
    end
  endfunction

  // Transmit word check: data, control bits and parity bit from pwdata.
  wire [7:0] tx_data_in = pwdata[7:0];
  wire [1:0] tx_control_in = pwdata[9:8];
  wire tx_parity_in = pwdata[10];
  wire coding_bypass = !tx_mode_bit1 && (decoder_select == `RXF_LVL_LOW);
  reg tx_cover_ctl;
  always @* begin
    tx_cover_ctl = 1'b0;
    // R09: high level covers control bits
    if (parity_control_select == `RXF_LVL_HIGH) begin
      tx_cover_ctl = 1'b1;
    // R08: bypass widens coverage
    end else if (parity_control_select == `RXF_LVL_MID && coding_bypass) begin
      tx_cover_ctl = 1'b1;
    end
  end
  wire tx_bad = !odd_ok({tx_cover_ctl ? tx_control_in : 2'h0, tx_data_in, tx_parity_in});
  wire check_on = (parity_control_select != `RXF_LVL_LOW);

  // Register writes and the sticky transmit parity error.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `RXF_CTRL_RESET;
      tx_perr_sticky <= 1'b0;
      tx_parity_error <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {20'h0_0000, pwdata[11:0]};
      end
      // R07: check transmit parity
      tx_parity_error <= wr_tx && check_on && tx_bad;
      // R18: sticky error, new error wins over clear
      if (wr_tx && check_on && tx_bad) begin
        tx_perr_sticky <= 1'b1;
      end else if (access && pwrite && paddr == `RXF_ADDR_STATUS && pwdata[0]) begin
        tx_perr_sticky <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial input synchroniser and bit deserialiser
  // ----------------------------------------------------------------
  reg sync1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync0 <= 1'b0;
      sync1 <= 1'b0;
    end else begin
      sync0 <= rx_serial_in;
      sync1 <= sync0;
    end
  end

  // Character strobe runs at a fixed phase; realignment only moves the
  // slicing offset into the shift register, so the clock never stretches.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= {2*CW{1'b0}};
      bit_cnt <= 4'h0;
      char_strobe <= 1'b0;
    end else begin
      shreg <= {sync1, shreg[2*CW-1:1]};
      // R02: fixed character clock phase
      if (bit_cnt == CW - 1) begin
        bit_cnt <= 4'h0;
        char_strobe <= 1'b1;
      end else begin
        bit_cnt <= bit_cnt + 1'b1;
        char_strobe <= 1'b0;
      end
    end
  end

  // Window at offset p within the last twenty bits.
  function [CW-1:0] slice;
    input [2*CW-1:0] s;
    input [3:0] p;
    begin
      slice = s[p +: CW];
    end
  endfunction

  // ----------------------------------------------------------------
  // Framer: search all offsets, realign after four in a row
  // ----------------------------------------------------------------
  reg hit_any;
  reg [3:0] hit_phase;
  integer k;
  always @* begin
    hit_any = 1'b0;
    hit_phase = 4'h0;
    for (k = CW - 1; k >= 0; k = k - 1) begin
      if (frame_hit(slice(shreg, k[3:0]), frchar)) begin
        hit_any = 1'b1;
        hit_phase = k[3:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 4'h0;
      align_run <= 3'h0;
      cand_phase <= 4'h0;
      locked <= 1'b0;
      rx_char <= {CW{1'b0}};
    end else if (char_strobe) begin
      rx_char <= slice(shreg, phase);
      if (!hit_any) begin
        align_run <= 3'h0;
      end else if (hit_phase != cand_phase) begin
        cand_phase <= hit_phase;
        align_run <= 3'h1;
      end else if (align_run != `RXF_ALIGN_COUNT) begin
        align_run <= align_run + 1'b1;
      end
      // R15: reframe only when allowed
      // R01: four aligned framing characters
      if (reframe_allow && frmode == `RXF_LVL_HIGH && hit_any && hit_phase == cand_phase &&
          align_run == `RXF_ALIGN_COUNT - 1'b1) begin
        phase <= cand_phase;
        locked <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Elasticity buffer with framing-character add and drop
  // ----------------------------------------------------------------
  wire fifo_in_ready;
  wire [CW-1:0] fifo_out;
  wire fifo_out_valid;
  wire [FIFO_AW:0] fifo_level;
  wire char_is_frame = frame_hit(rx_char, frchar);
  reg char_new;
  // R11: buffer used only with reference-clock output
  wire use_eb = !rx_clock_source_select;
  // R14: drop a framing character when the buffer level reaches HIGH_MARK
  wire drop_now = use_eb && char_new && char_is_frame && (fifo_level >= HIGH_MARK);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      char_new <= 1'b0;
    end else begin
      char_new <= char_strobe;
    end
  end

  rxf_fifo #(.WIDTH(CW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) rxf_fifo_i (
    .pclk(pclk),
    .presetn(presetn),
    .in_data(rx_char),
    .in_valid(char_new && !drop_now),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(use_eb ? (!held_valid && !insert_pend) : 1'b1),
    .level(fifo_level)
  );

  // Output stage: a framing character leaving a near-empty buffer arms
  // one inserted K28.5 right behind it, the only way characters are added.
  wire [CW-1:0] next_char = insert_pend ? `RXF_K285_NEG : fifo_out;
  wire take = use_eb ? (!held_valid && (insert_pend || fifo_out_valid)) : fifo_out_valid;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_char <= {CW{1'b0}};
      held_valid <= 1'b0;
      insert_pend <= 1'b0;
    end else begin
      held_valid <= 1'b0;
      if (take) begin
        held_char <= next_char;
        held_valid <= 1'b1;
        // R12: compensate only by framing characters
        // R13: insert one K28.5 after a framing character
        insert_pend <= !insert_pend && use_eb && frame_hit(fifo_out, frchar) &&
                       (fifo_level < LOW_MARK);
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive output register and parity generation
  // ----------------------------------------------------------------
  reg [2:0] status;
  reg [2:0] rx_cover;
  always @* begin
    status = {locked, held_char[9:8]};
    rx_cover = 3'h0;
    // R09: generate over all status bits
    if (parity_control_select == `RXF_LVL_HIGH) begin
      rx_cover = 3'h7;
    // R08: generate over status 1:0 in bypass
    end else if (parity_control_select == `RXF_LVL_MID && coding_bypass) begin
      rx_cover = 3'h3;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_out <= 8'h00;
      rx_status_out <= 3'h0;
      rx_parity_out <= 1'b0;
      rx_parity_oe <= 1'b0;
      rx_word <= 10'h000;
      rx_word_valid <= 1'b0;
    end else begin
      if (held_valid) begin
        // R16: raw 10-bit character, no decoding here
        rx_data_out <= held_char[7:0];
        rx_status_out <= status;
        // R07: odd parity on receive byte
        rx_parity_out <= ~^{held_char[7:0], status & rx_cover};
        rx_word <= held_char;
        rx_word_valid <= 1'b1;
      end else if (rd_rx) begin
        rx_word_valid <= 1'b0;
      end
      // R06: parity output released when disabled
      rx_parity_oe <= check_on;
    end
  end

  assign rx_word_ready = rx_word_valid;

  // Read data multiplexer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `RXF_ADDR_CTRL: prdata <= ctrl;
        `RXF_ADDR_STATUS: prdata <= {24'h00_0000, fifo_level, fifo_in_ready, locked,
                                     tx_perr_sticky};
        `RXF_ADDR_RXWORD: prdata <= {rx_word_valid, 21'h00_0000, rx_word};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// >>> tb/rxf_link_model.sv
// Serial link partner model: sends queued bits, one per clock, bit 0 first.
`timescale 1ns/1ps
module rxf_link_model (
  input wire pclk,
  output logic rx_serial
);
  logic q[$];
  // Queue n bits of v, lowest first, in line order.
  task automatic push_bits(input logic [9:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      q.push_back(v[i]);
    end
  endtask
  initial rx_serial = 1'b0;
  // With nothing queued the line toggles, so a stale bit never passes for live data.
  always @(posedge pclk) begin
    if (q.size() > 0) begin
      rx_serial <= q.pop_front();
    end else begin
      rx_serial <= ~rx_serial;
    end
  end
endmodule

// >>> tb/rxf_top_properties.sv
// Port-level assertions for the receive framer, parity and elasticity block.
`timescale 1ns/1ps
`include "rxf_defines.vh"
module rxf_top_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] rx_data_out,
  input wire [2:0] rx_status_out,
  input wire rx_parity_out,
  input wire rx_parity_oe,
  input wire tx_parity_error
);
  logic [31:0] ctrl_q;
  wire acc = psel && penable;
  wire mapped = paddr == `RXF_ADDR_CTRL || paddr == `RXF_ADDR_STATUS ||
    paddr == `RXF_ADDR_TXWORD || paddr == `RXF_ADDR_RXWORD;
  wire wr_tx = acc && pwrite && paddr == `RXF_ADDR_TXWORD;
  wire [1:0] par = ctrl_q[5:4];
  wire byp = !ctrl_q[6] && ctrl_q[8:7] == 2'h0;
  // Shadow of the control register, so the checks know the static settings.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h0000_0000;
    end else if (acc && pwrite && paddr == `RXF_ADDR_CTRL) begin
      ctrl_q <= pwdata;
    end
  end
  // True when a transmit word breaks odd parity under settings c.
  function automatic logic tx_bad(input logic [31:0] c, input logic [31:0] w);
    case (c[5:4])
      `RXF_LVL_MID: tx_bad = (!c[6] && c[8:7] == 2'h0) ? ~^w[10:0] : ~^{w[10], w[7:0]};
      `RXF_LVL_HIGH: tx_bad = ~^w[10:0];
      default: tx_bad = 1'b0;
    endcase
  endfunction
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_high_a: assert property (acc |-> pready)
    else $error("pready low in an access cycle");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  parity_release_a: assert property (par == 2'h0 && $past(par) == 2'h0 |-> !rx_parity_oe)
    else $error("parity output driven while parity is off");
  parity_drive_a: assert property (par != 2'h0 && $past(par) != 2'h0 |-> rx_parity_oe)
    else $error("parity output released while parity is on");
  parity_mid_a: assert property ($stable(ctrl_q) && par == `RXF_LVL_MID && !byp &&
    $changed(rx_data_out) |-> rx_parity_out == ~^rx_data_out)
    else $error("receive parity wrong in middle coded mode");
  parity_bypass_a: assert property ($stable(ctrl_q) && par == `RXF_LVL_MID && byp &&
    $changed({rx_data_out, rx_status_out[1:0]}) |->
    rx_parity_out == ~^{rx_data_out, rx_status_out[1:0]})
    else $error("receive parity wrong in bypass mode");
  parity_high_a: assert property ($stable(ctrl_q) && par == `RXF_LVL_HIGH &&
    $changed({rx_data_out, rx_status_out[1:0]}) && $stable(rx_status_out[2]) |->
    rx_parity_out == ~^{rx_data_out, rx_status_out})
    else $error("receive parity wrong in high mode");
  txerr_set_a: assert property (wr_tx && tx_bad(ctrl_q, pwdata) |=> tx_parity_error)
    else $error("bad transmit word not flagged");
  txerr_quiet_a: assert property (wr_tx && !tx_bad(ctrl_q, pwdata) |=> !tx_parity_error)
    else $error("good transmit word flagged");
  txerr_pulse_a: assert property (tx_parity_error |=> !tx_parity_error)
    else $error("parity error pulse longer than one cycle");
  k_insert_a: assert property ($stable(ctrl_q) && !ctrl_q[10] && ctrl_q[3:2] != 2'h0 &&
    $changed(rx_data_out) && {rx_status_out[1:0], rx_data_out} == `RXF_K285_POS |->
    ##2 {rx_status_out[1:0], rx_data_out} == `RXF_K285_NEG)
    else $error("no framing character added behind a buffered one");
  cover property (acc && !mapped);
  cover property (tx_parity_error);
  cover property ($rose(rx_status_out[2]));
endmodule
bind rxf_top rxf_top_checker rxf_top_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_data_out(rx_data_out),
  .rx_status_out(rx_status_out), .rx_parity_out(rx_parity_out),
  .rx_parity_oe(rx_parity_oe), .tx_parity_error(tx_parity_error));

// >>> tb/rxf_top_tb_top.sv
// Self-checking bench for the receive framer, parity and elasticity block.
`timescale 1ns/1ps
`include "rxf_defines.vh"
module rxf_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr, rx_serial_in, rx_word_ready, rx_parity_out, rx_parity_oe;
  wire tx_parity_error;
  wire [7:0] rx_data_out;
  wire [2:0] rx_status_out;
  int error_cnt = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic err;
  localparam logic [9:0] DCH [0:5] = '{10'h2aa, 10'h155, 10'h0f0, 10'h30c, 10'h1b3, 10'h264};
  rxf_top rxf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_serial_in(rx_serial_in), .rx_word_ready(rx_word_ready),
    .rx_data_out(rx_data_out), .rx_status_out(rx_status_out),
    .rx_parity_out(rx_parity_out), .rx_parity_oe(rx_parity_oe),
    .tx_parity_error(tx_parity_error));
  rxf_link_model rxf_link_model_i (.pclk(pclk), .rx_serial(rx_serial_in));
  always #50 pclk = ~pclk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; read data and the error flag are taken at the ready edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      check("pready", 0, 1);
      finish_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic [31:0] ctrl);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `RXF_ADDR_CTRL, ctrl);
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 3000 && rxf_link_model_i.q.size() > 0; n++) @(posedge pclk);
    if (n >= 3000) begin
      check("link_idle", 0, 1);
      finish_test;
    end
    repeat (20) @(posedge pclk);
  endtask
  // Three stray bits put the characters off the reset boundary.
  task automatic send(input int nk, input int nd, input int nt);
    rxf_link_model_i.push_bits(10'h005, 3);
    for (int i = 0; i < nk + nd + nt; i++) begin
      if (i >= nk && i < nk + nd) begin
        rxf_link_model_i.push_bits(DCH[i-nk], 10);
      end else begin
        rxf_link_model_i.push_bits(i % 2 ? `RXF_K285_POS : `RXF_K285_NEG, 10);
      end
    end
  endtask
  task automatic wait_lock;
    int n;
    rd = 0;
    for (n = 0; n < 150 && rd[1] !== 1'b1; n++) apb(1'b0, `RXF_ADDR_STATUS, 0);
    check("locked", rd[1], 1);
    if (rd[1] !== 1'b1) finish_test;
  endtask
  // Words after the first framing character must be the sent data, in order.
  task automatic collect(input int nd);
    int got;
    int seen_k;
    got = 0;
    seen_k = 0;
    for (int t = 0; t < 400 && got < nd; t++) begin
      apb(1'b0, `RXF_ADDR_RXWORD, 0);
      if (rd[31] === 1'b1) begin
        if (rd[9:0] === `RXF_K285_NEG || rd[9:0] === `RXF_K285_POS) begin
          seen_k = 1;
        end else if (seen_k) begin
          check("rx_word", rd[9:0], DCH[got]);
          got++;
        end
      end
    end
    check("rx_word_count", got, nd);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_regs;
    apb(1'b0, `RXF_ADDR_CTRL, 0);
    check("ctrl_reset", rd, `RXF_CTRL_RESET);
    apb(1'b0, `RXF_ADDR_STATUS, 0);
    check("status_reset", rd[1:0], 0);
    apb(1'b1, `RXF_ADDR_CTRL, 32'h0000_0c0a);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    check("unmapped_wr_err", err, 1);
    apb(1'b0, 12'h010, 0);
    check("unmapped_rd_err", err, 1);
    check("unmapped_rd", rd, 0);
    apb(1'b0, `RXF_ADDR_CTRL, 0);
    check("ctrl_back", rd[11:0], 12'hc0a);
  endtask
  // framing select held high, never at its test-only low level.
  localparam logic [31:0] PC [0:6] = '{32'h0000_00c8, 32'h0000_00d8, 32'h0000_00d8,
    32'h0000_0018, 32'h0000_0018, 32'h0000_00e8, 32'h0000_00e8};
  localparam logic [31:0] PW [0:6] = '{32'h0000_0000, 32'h0000_0301, 32'h0000_0300,
    32'h0000_0101, 32'h0000_0501, 32'h0000_0101, 32'h0000_0001};
  localparam logic PE [0:6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  task automatic s_parity;
    for (int i = 0; i < 7; i++) begin
      do_reset(PC[i]);
      send(0, 3, 0);
      apb(1'b1, `RXF_ADDR_TXWORD, PW[i]);
      apb(1'b0, `RXF_ADDR_STATUS, 0);
      check("tx_err_sticky", rd[0], PE[i]);
      @(negedge pclk);
      check("parity_oe", rx_parity_oe, PC[i][5:4] != 2'h0);
      apb(1'b1, `RXF_ADDR_STATUS, 32'h0000_0001);
      apb(1'b0, `RXF_ADDR_STATUS, 0);
      check("tx_err_clear", rd[0], 0);
      wait_idle;
    end
  endtask
  localparam logic [31:0] LC [0:3] = '{32'h0000_0c0a, 32'h0000_040a, 32'h0000_0c09,
    32'h0000_0c0a};
  localparam int LN [0:3] = '{3, 8, 8, 4};
  task automatic s_lock;
    for (int i = 0; i < 4; i++) begin
      do_reset(LC[i]);
      send(LN[i], 1, 0);
      wait_idle;
      apb(1'b0, `RXF_ADDR_STATUS, 0);
      check("lock_count", rd[1], i == 3);
    end
  endtask
  // Full K28.5 framing, receive buffer bypassed.
  task automatic s_direct;
    do_reset(32'h0000_0c0a);
    send(8, 6, 8);
    wait_lock;
    collect(6);
    wait_idle;
    check("word_ready", rx_word_ready, 1);
  endtask
  // Comma framing through the elasticity buffer; one clock leaves no drift to absorb.
  task automatic s_buffered;
    do_reset(32'h0000_0806);
    send(8, 6, 30);
    wait_lock;
    collect(6);
    wait_idle;
    apb(1'b0, `RXF_ADDR_STATUS, 0);
    check("fifo_not_full", rd[2], 1);
    check("fifo_below_drop", rd[7:3] < 5'h0c, 1);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_regs;
    s_parity;
    s_lock;
    s_direct;
    s_buffered;
    finish_test;
  end
endmodule
